//--- capacity_request_engine.v
// Purpose: Slot pool merge, control slot fill, capacity requests
// Assumes: Classic Wishbone slave, one clock, sync active-low reset
// Notes:   Volume values are in units of 2^gran bytes
//
// Overview of operation
// [R01] Merge static and dynamic slots per content type
// [R02] Logged on: fill every dedicated control slot
// [R03] Never request what constant rate covers; incremental requests do not deduct cra_mem from arrivals
// [R04] Use unsolicited slots for queued traffic
// [R05] Controller reduces backlog by assigned volume
// [R06] Controller may expire idle volume backlog
// [R07] Per-class timer infers controller backlog expiry
// [R08] Cap requests to advertised backlog headroom
// [R09] Volume requests off until support advertised
// [R10] Absolute request replaces earlier volume requests
// [R11] Absolute when backlog expired or grown from zero
// [R12] Absolute value equals quantised current backlog
// [R13] Controller accumulates incremental requests
// [R14] Incremental value equals quantised new arrivals
// [R15] Each rate request overrides earlier ones
// [R16] Controller may expire idle rate request
// [R17] Rate capped at maximum minus constant rate
// [R18] Controller accepts rates up to supported level
// [R19] Rate requests off until support advertised
// [R20] Requests generated independently per class
// [R21] At least three concurrent request classes
// [R22] Use rate or volume as controller selects
// [R23] Timers tick per superframe, reload on request
`include "cre_consts.vh"
`default_nettype none

module capacity_request_engine #(
  parameter NCLASS = 3,
  parameter VW     = 16
) (
  input  wire                core_clk_i,
  input  wire                nrst_i,
  input  wire                wb_cyc_i,
  input  wire                wb_stb_i,
  input  wire                wb_we_i,
  input  wire [7:0]          wb_adr_i,
  input  wire [3:0]          wb_sel_i,
  input  wire [31:0]         wb_dat_i,
  output reg  [31:0]         wb_dat_o,
  output reg                 wb_ack_o,
  input  wire                sf_tick_i,
  input  wire                slot_strobe_i,
  input  wire [3:0]          static_pool_i,
  input  wire [3:0]          dynamic_pool_i,
  input  wire                logon_pending_i,
  input  wire                qos_hold_i,
  output reg  [3:0]          slot_pool_o,
  output reg                 logon_burst_o,
  output reg                 control_burst_o,
  output reg                 traffic_burst_o,
  input  wire                arrive_valid_i,
  input  wire [1:0]          arrive_class_i,
  input  wire [VW-1:0]       arrive_bytes_i,
  input  wire [NCLASS*VW-1:0] backlog_i,
  input  wire [NCLASS*VW-1:0] rate_demand_i,
  input  wire                grant_valid_i,
  input  wire [1:0]          grant_class_i,
  input  wire [VW-1:0]       grant_vol_i,
  output reg  [NCLASS-1:0]   vreq_valid_o,
  output reg  [NCLASS-1:0]   vreq_abs_o,
  output reg  [NCLASS*VW-1:0] vreq_value_o,
  output reg  [NCLASS-1:0]   rreq_valid_o,
  output reg  [NCLASS*VW-1:0] rreq_value_o
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function [VW-1:0] sat_sub;
    input [VW-1:0] a;
    input [VW-1:0] b;
    begin
      sat_sub = (a > b) ? (a - b) : {VW{1'b0}};
    end
  endfunction

  function [VW-1:0] min_of;
    input [VW-1:0] a;
    input [VW-1:0] b;
    begin
      min_of = (a < b) ? a : b;
    end
  endfunction

  // Rounds up, so a partial unit still gets solicited
  function [VW-1:0] quant;
    input [VW-1:0] x;
    input [3:0]    sh;
    reg   [VW:0]   t;
    begin
      t = {1'b0, x} + (({{VW{1'b0}}, 1'b1} << sh) - {{VW{1'b0}}, 1'b1});
      t     = t >> sh;
      quant = t[VW-1:0];
    end
  endfunction

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  reg  [15:0]       ctrl_reg;
  reg  [7:0]        vtmo_reg;
  reg  [7:0]        rtmo_reg;
  reg  [15:0]       ctl_cnt_reg;
  reg  [VW-1:0]     cra_mem  [0:NCLASS-1];
  reg  [VW-1:0]     maxr_mem [0:NCLASS-1];
  reg  [VW-1:0]     maxb_mem [0:NCLASS-1];
  reg  [VW-1:0]     est_mem  [0:NCLASS-1];
  reg  [VW-1:0]     acc_mem  [0:NCLASS-1];
  reg  [VW-1:0]     lastr_mem[0:NCLASS-1];
  reg  [NCLASS-1:0] zero_seen_reg;
  wire [NCLASS-1:0] valive;
  wire [NCLASS-1:0] ralive;
  reg  [NCLASS-1:0] valive_d_reg;

  wire             logged_on = ctrl_reg[`CRE_LOGON_BIT];
  wire [NCLASS-1:0] vsup     = ctrl_reg[`CRE_VSUP_LSB +: NCLASS];
  wire [NCLASS-1:0] rsup     = ctrl_reg[`CRE_RSUP_LSB +: NCLASS];
  wire [3:0]        gran     = ctrl_reg[`CRE_GRAN_LSB +: 4];

  // ------------------------------------------------------------
  // Wishbone slave
  // ------------------------------------------------------------
  wire       wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire [3:0] grp    = wb_adr_i[7:4];
  wire [1:0] idx    = wb_adr_i[3:2];
  wire       idx_ok = ({30'h0, idx} < NCLASS);
  reg  [31:0] rd_data;
  integer     r;

  always @* begin
    rd_data = 32'h0000_0000;
    if (wb_adr_i == `CRE_CTRL_OFS) begin
      rd_data = {16'h0000, ctrl_reg};
    end else if (wb_adr_i == `CRE_TMO_OFS) begin
      rd_data = {16'h0000, rtmo_reg, vtmo_reg};
    end else if (wb_adr_i == `CRE_CNT_OFS) begin
      rd_data = {16'h0000, ctl_cnt_reg};
    end else if (idx_ok) begin
      case (grp)
        `CRE_CRA_BASE:  rd_data[VW-1:0] = cra_mem[idx];
        `CRE_MAXR_BASE: rd_data[VW-1:0] = maxr_mem[idx];
        `CRE_MAXB_BASE: rd_data[VW-1:0] = maxb_mem[idx];
        `CRE_STAT_BASE: begin
          rd_data[VW-1:0]          = est_mem[idx];
          rd_data[`CRE_VALIVE_BIT] = valive[idx];
          rd_data[`CRE_RALIVE_BIT] = ralive[idx];
        end
        default:        rd_data = 32'h0000_0000;
      endcase
    end
  end

  // Lane merge for 16-bit fields
  function [15:0] lane16;
    input [15:0] old;
    input [31:0] d;
    input [3:0]  s;
    begin
      lane16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    end
  endfunction

  always @(posedge core_clk_i) begin
    if (!nrst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ctrl_reg <= `CRE_CTRL_RST; // [R09] [R19]
      vtmo_reg <= `CRE_VTMO_RST;
      rtmo_reg <= `CRE_RTMO_RST;
      for (r = 0; r < NCLASS; r = r + 1) begin
        cra_mem[r]  <= `CRE_LVL_RST;
        maxr_mem[r] <= `CRE_LVL_RST;
        maxb_mem[r] <= `CRE_LVL_RST;
      end
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req) begin
        wb_dat_o <= rd_data;
      end
      if (wb_req && wb_we_i) begin
        if (wb_adr_i == `CRE_CTRL_OFS) begin
          ctrl_reg <= lane16(ctrl_reg, wb_dat_i, wb_sel_i);
        end else if (wb_adr_i == `CRE_TMO_OFS) begin
          if (wb_sel_i[0]) vtmo_reg <= wb_dat_i[7:0];
          if (wb_sel_i[1]) rtmo_reg <= wb_dat_i[15:8];
        end else if (idx_ok && grp == `CRE_CRA_BASE) begin
          cra_mem[idx] <= lane16(cra_mem[idx], wb_dat_i, wb_sel_i);
        end else if (idx_ok && grp == `CRE_MAXR_BASE) begin
          maxr_mem[idx] <= lane16(maxr_mem[idx], wb_dat_i, wb_sel_i);
        end else if (idx_ok && grp == `CRE_MAXB_BASE) begin
          maxb_mem[idx] <= lane16(maxb_mem[idx], wb_dat_i, wb_sel_i);
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Slot pool and burst use
  // ------------------------------------------------------------
  wire [3:0] pool = static_pool_i | dynamic_pool_i; // [R01]
  wire       any_backlog = |backlog_i;

  always @(posedge core_clk_i) begin
    if (!nrst_i) begin
      slot_pool_o     <= 4'h0;
      logon_burst_o   <= 1'b0;
      control_burst_o <= 1'b0;
      traffic_burst_o <= 1'b0;
      ctl_cnt_reg     <= 16'h0000;
    end else begin
      slot_pool_o     <= slot_strobe_i ? pool : 4'h0;
      logon_burst_o   <= slot_strobe_i && pool[`CT_LOGON] && !logged_on && logon_pending_i;
      control_burst_o <= slot_strobe_i && pool[`CT_CONTROL] && logged_on; // [R02]
      // Hold input lets QoS shaping leave a slot unused
      traffic_burst_o <= slot_strobe_i && logged_on && any_backlog && !qos_hold_i &&
                         (pool[`CT_TRAFFIC] || pool[`CT_TRAFCTL]); // [R04]
      if (slot_strobe_i && pool[`CT_CONTROL] && logged_on) begin
        ctl_cnt_reg <= ctl_cnt_reg + 16'h0001;
      end
    end
  end

  // ------------------------------------------------------------
  // Per-class request decisions
  // ------------------------------------------------------------
  reg [NCLASS-1:0] vsend;
  reg [NCLASS-1:0] vabs;
  reg [NCLASS-1:0] rsend;
  reg [VW-1:0]     vval [0:NCLASS-1];
  reg [VW-1:0]     rval [0:NCLASS-1];
  reg [VW-1:0]     need;
  reg [VW-1:0]     absv;
  reg [VW-1:0]     incv;
  integer          c;

  always @* begin
    need = {VW{1'b0}};
    absv = {VW{1'b0}};
    incv = {VW{1'b0}};
    for (c = 0; c < NCLASS; c = c + 1) begin // [R20] [R21]
      need    = sat_sub(backlog_i[c*VW +: VW], cra_mem[c]); // [R03]
      absv    = min_of(quant(need, gran), maxb_mem[c]); // [R12] [R08]
      incv    = min_of(quant(acc_mem[c], gran), sat_sub(maxb_mem[c], est_mem[c])); // [R14] [R08]
      vabs[c] = !valive[c] || (zero_seen_reg[c] && backlog_i[c*VW +: VW] != {VW{1'b0}}); // [R11]
      vval[c] = vabs[c] ? absv : incv;
      vsend[c] = sf_tick_i && vsup[c] && vval[c] != {VW{1'b0}}; // [R09] [R22]
      rval[c] = min_of(rate_demand_i[c*VW +: VW], sat_sub(maxr_mem[c], cra_mem[c])); // [R17]
      rsend[c] = sf_tick_i && rsup[c] && (rval[c] != lastr_mem[c] ||
                 (!ralive[c] && rval[c] != {VW{1'b0}})); // [R19] [R22]
    end
  end

  genvar g;
  generate
    for (g = 0; g < NCLASS; g = g + 1) begin : g_tmr
      idle_timer #(.TW(8)) u_vtmr (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .tick_i     (sf_tick_i),
        .reload_i   (vsend[g]),
        .timeout_i  (vtmo_reg),
        .alive_o    (valive[g])
      ); // [R07]
      idle_timer #(.TW(8)) u_rtmr (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .tick_i     (sf_tick_i),
        .reload_i   (rsend[g]),
        .timeout_i  (rtmo_reg),
        .alive_o    (ralive[g])
      ); // [R16]
    end
  endgenerate

  // ------------------------------------------------------------
  // Per-class state and request outputs
  // ------------------------------------------------------------
  integer k;

  always @(posedge core_clk_i) begin
    if (!nrst_i) begin
      vreq_valid_o  <= {NCLASS{1'b0}};
      vreq_abs_o    <= {NCLASS{1'b0}};
      vreq_value_o  <= {NCLASS*VW{1'b0}};
      rreq_valid_o  <= {NCLASS{1'b0}};
      rreq_value_o  <= {NCLASS*VW{1'b0}};
      zero_seen_reg <= {NCLASS{1'b1}};
      valive_d_reg  <= {NCLASS{1'b0}};
      for (k = 0; k < NCLASS; k = k + 1) begin
        est_mem[k]   <= {VW{1'b0}};
        acc_mem[k]   <= {VW{1'b0}};
        lastr_mem[k] <= {VW{1'b0}};
      end
    end else begin
      vreq_valid_o <= vsend;
      vreq_abs_o   <= vsend & vabs;
      rreq_valid_o <= rsend;
      valive_d_reg <= valive;
      for (k = 0; k < NCLASS; k = k + 1) begin
        if (vsend[k]) begin
          vreq_value_o[k*VW +: VW] <= vval[k];
          // Mirror of controller backlog: absolute replaces, incremental adds
          est_mem[k] <= vabs[k] ? vval[k] : est_mem[k] + vval[k]; // [R10] [R13]
        end else if (!valive[k] && valive_d_reg[k]) begin
          est_mem[k] <= {VW{1'b0}}; // [R06]
        end else if (grant_valid_i && {30'h0, grant_class_i} == k) begin
          est_mem[k] <= sat_sub(est_mem[k], grant_vol_i); // [R05]
        end
        // Arrival in the request cycle is kept for the next request
        if (arrive_valid_i && {30'h0, arrive_class_i} == k) begin
          acc_mem[k] <= (vsend[k] ? {VW{1'b0}} : acc_mem[k]) + arrive_bytes_i; // [R14]
        end else if (vsend[k]) begin
          acc_mem[k] <= {VW{1'b0}};
        end
        if (backlog_i[k*VW +: VW] == {VW{1'b0}}) begin
          zero_seen_reg[k] <= 1'b1;
        end else if (vsend[k]) begin
          zero_seen_reg[k] <= 1'b0; // [R11]
        end
        if (rsend[k]) begin
          rreq_value_o[k*VW +: VW] <= rval[k];
          lastr_mem[k] <= rval[k]; // [R15]
        end
      end
    end
  end

endmodule // capacity_request_engine

`default_nettype wire

//--- cre_consts.vh
// Purpose: Constants for the capacity request engine
// Assumes: Wishbone byte addresses, 32-bit data words
// Notes:   Register offsets, field positions, reset values
`ifndef CRE_CONSTS_VH
`define CRE_CONSTS_VH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define CRE_CTRL_OFS  8'h00
`define CRE_TMO_OFS   8'h04
`define CRE_CNT_OFS   8'h0c
`define CRE_CRA_BASE  4'h1
`define CRE_MAXR_BASE 4'h2
`define CRE_MAXB_BASE 4'h3
`define CRE_STAT_BASE 4'h4

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define CRE_LOGON_BIT 0
`define CRE_VSUP_LSB  4
`define CRE_RSUP_LSB  8
`define CRE_GRAN_LSB  12
`define CRE_VTMO_LSB  0
`define CRE_RTMO_LSB  8
`define CRE_VALIVE_BIT 16
`define CRE_RALIVE_BIT 17

// ------------------------------------------------------------
// Content type bits of a slot pool
// ------------------------------------------------------------
`define CT_LOGON   0
`define CT_CONTROL 1
`define CT_TRAFCTL 2
`define CT_TRAFFIC 3

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define CRE_CTRL_RST 16'h0000
`define CRE_VTMO_RST 8'h01
`define CRE_RTMO_RST 8'h01
`define CRE_LVL_RST  16'h0000

`endif

//--- idle_timer.v
// Purpose: Superframe idle timer for one request class
// Assumes: tick_i is a one-cycle superframe pulse
// Notes:   Alive while count is non-zero
`default_nettype none

module idle_timer #(
  parameter TW = 8
) (
  input  wire          core_clk_i,
  input  wire          nrst_i,
  input  wire          tick_i,
  input  wire          reload_i,
  input  wire [TW-1:0] timeout_i,
  output wire          alive_o
);

  reg [TW-1:0] count_reg;

  always @(posedge core_clk_i) begin
    if (!nrst_i) begin
      count_reg <= {TW{1'b0}};
    end else if (reload_i) begin
      count_reg <= timeout_i; // [R23]
    end else if (tick_i && count_reg != {TW{1'b0}}) begin
      count_reg <= count_reg - {{(TW-1){1'b0}}, 1'b1}; // [R23]
    end
  end

  assign alive_o = (count_reg != {TW{1'b0}});

endmodule // idle_timer

`default_nettype wire

//--- cre_monitor.sv
// Purpose: Port-level assertions for the capacity request engine
// Assumes: Single clock, synchronous active-low reset
// Notes:   Attached by bind at the foot of this file
`default_nettype none

module cre_monitor #(
  parameter NCLASS = 3,
  parameter VW     = 16
) (
  input wire logic                 core_clk_i, nrst_i, wb_cyc_i, wb_stb_i, wb_ack_o,
  input wire logic                 sf_tick_i, slot_strobe_i, qos_hold_i,
  input wire logic [3:0]           static_pool_i, dynamic_pool_i, slot_pool_o,
  input wire logic                 logon_burst_o, control_burst_o, traffic_burst_o,
  input wire logic [NCLASS-1:0]    vreq_valid_o, vreq_abs_o, rreq_valid_o,
  input wire logic [NCLASS*VW-1:0] vreq_value_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_pool_merge: assert property (slot_strobe_i |=>
    slot_pool_o == $past(static_pool_i | dynamic_pool_i)) else $error("pool not merged");
  a_pool_quiet: assert property (!slot_strobe_i |=> slot_pool_o == 4'h0)
    else $error("pool outside slot");
  a_burst_cause: assert property ((logon_burst_o | control_burst_o | traffic_burst_o)
    |-> $past(slot_strobe_i)) else $error("burst without slot");
  a_ctrl_kind: assert property (control_burst_o |-> slot_pool_o[1] && !logon_burst_o)
    else $error("control burst in wrong slot");
  a_traffic_hold: assert property (traffic_burst_o |->
    (slot_pool_o[3] | slot_pool_o[2]) && !$past(qos_hold_i)) else $error("bad traffic burst");
  a_req_on_tick: assert property ((|vreq_valid_o || |rreq_valid_o) |->
    $past(sf_tick_i)) else $error("request without tick");
  a_vol_nonzero: assert property (vreq_valid_o[0] |-> vreq_value_o[VW-1:0] != 0)
    else $error("zero volume request");
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");

  c_control: cover property (control_burst_o);
  c_absolute: cover property (vreq_valid_o[0] && vreq_abs_o[0]);
  c_rate: cover property (rreq_valid_o[1]);
endmodule // cre_monitor

bind capacity_request_engine cre_monitor #(.NCLASS(NCLASS), .VW(VW)) mon (
  .core_clk_i, .nrst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .sf_tick_i, .slot_strobe_i,
  .qos_hold_i, .static_pool_i, .dynamic_pool_i, .slot_pool_o, .logon_burst_o,
  .control_burst_o, .traffic_burst_o, .vreq_valid_o, .vreq_abs_o, .rreq_valid_o,
  .vreq_value_o);
`default_nettype wire

//--- network_controller_model.sv
// Purpose: Far-side request bookkeeping and volume grants
// Assumes: Grants of one unit, issued on command from the bench
// Notes:   Idle grant fields toggle so stale values are never trusted
`default_nettype none

module network_controller_model (
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        tick_i,
  input  wire logic [7:0]  vtmo_i,
  input  wire logic [7:0]  rtmo_i,
  input  wire logic        go_i,
  input  wire logic [1:0]  go_class_i,
  input  wire logic [2:0]  vreq_valid_i,
  input  wire logic [2:0]  vreq_abs_i,
  input  wire logic [2:0]  rreq_valid_i,
  input  wire logic [47:0] vreq_value_i,
  input  wire logic [47:0] rreq_value_i,
  output var  logic        grant_valid_o,
  output var  logic [1:0]  grant_class_o,
  output var  logic [15:0] grant_vol_o,
  output var  logic [15:0] bl0_o,
  output var  logic [15:0] r1_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] vbl [3];
  logic [15:0] rlast [3];
  // Superframes since the last request; all ones means parked
  logic [7:0]  vage [3];
  logic [7:0]  rage [3];
  assign bl0_o = vbl[0];
  assign r1_o  = rlast[1];

  always @(posedge core_clk_i) begin
    grant_valid_o <= 1'b0;
    grant_class_o <= ~grant_class_o;
    grant_vol_o   <= ~grant_vol_o;
    if (!nrst_i) begin
      grant_class_o <= 2'h0;
      grant_vol_o   <= 16'h0000;
      for (int c = 0; c < 3; c++) begin
        vbl[c]   <= 16'h0000;
        rlast[c] <= 16'h0000;
        vage[c]  <= 8'hff;
        rage[c]  <= 8'hff;
      end
    end else begin
      for (int c = 0; c < 3; c++) begin
        // Idle expiry drops the backlog unhonoured and forgets the rate
        if (tick_i && vage[c] != 8'hff) begin
          vage[c] <= vage[c] + 8'h01;
          if (vage[c] + 8'h01 == vtmo_i) begin
            vbl[c] <= 16'h0000;
          end
        end
        if (tick_i && rage[c] != 8'hff) begin
          rage[c] <= rage[c] + 8'h01;
          if (rage[c] + 8'h01 == rtmo_i) begin
            rlast[c] <= 16'h0000;
          end
        end
        if (vreq_valid_i[c]) begin
          vage[c] <= 8'h00;
          vbl[c]  <= vreq_abs_i[c] ? vreq_value_i[c*16+:16] :
                     vbl[c] + vreq_value_i[c*16+:16];
        end
        if (rreq_valid_i[c]) begin
          rage[c]  <= 8'h00;
          rlast[c] <= rreq_value_i[c*16+:16];
        end
      end
      if (go_i) begin
        grant_valid_o <= 1'b1;
        grant_class_o <= go_class_i;
        grant_vol_o   <= 16'h0001;
        vbl[go_class_i] <= vbl[go_class_i] - 16'h0001;
      end
    end
  end
endmodule // network_controller_model
`default_nettype wire

//--- capacity_request_engine_tb.sv
// Purpose: Directed scenarios for the capacity request engine
// Assumes: Wishbone answer one cycle after the take edge
// Notes:   Granularity shift 8, so one unit is 256 bytes
`default_nettype none

module capacity_request_engine_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        core_clk_i, nrst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, sf_tick_i;
  logic        slot_strobe_i, logon_pending_i, qos_hold_i, arrive_valid_i, grant_valid_i, go;
  logic        logon_burst_o, control_burst_o, traffic_burst_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i, static_pool_i, dynamic_pool_i, slot_pool_o;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [1:0]  arrive_class_i, grant_class_i, go_class;
  logic [15:0] arrive_bytes_i, grant_vol_i, bl0, r1;
  logic [2:0]  vreq_valid_o, vreq_abs_o, rreq_valid_o;
  logic [47:0] backlog_i, rate_demand_i, vreq_value_o, rreq_value_o;
  int          mismatches, samples_checked, cycles;

  capacity_request_engine dut (.core_clk_i, .nrst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .sf_tick_i, .slot_strobe_i,
    .static_pool_i, .dynamic_pool_i, .logon_pending_i, .qos_hold_i, .slot_pool_o,
    .logon_burst_o, .control_burst_o, .traffic_burst_o, .arrive_valid_i, .arrive_class_i,
    .arrive_bytes_i, .backlog_i, .rate_demand_i, .grant_valid_i, .grant_class_i,
    .grant_vol_i, .vreq_valid_o, .vreq_abs_o, .vreq_value_o, .rreq_valid_o, .rreq_value_o);
  network_controller_model ctl (.core_clk_i, .nrst_i, .tick_i(sf_tick_i), .vtmo_i(8'h02),
    .rtmo_i(8'h01), .r1_o(r1), .go_i(go), .go_class_i(go_class),
    .vreq_valid_i(vreq_valid_o), .vreq_abs_i(vreq_abs_o), .rreq_valid_i(rreq_valid_o),
    .vreq_value_i(vreq_value_o), .rreq_value_i(rreq_value_o), .grant_valid_o(grant_valid_i),
    .grant_class_o(grant_class_i), .grant_vol_o(grant_vol_i), .bl0_o(bl0));

  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  // Hang guard, the whole run needs about a hundred cycles
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      test_done();
    end
  end

  task automatic chk(input logic [47:0] s, input logic [47:0] e);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
    // Only the global cycle guard ends a wait that never sees ack
    do begin
      @(posedge core_clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge core_clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask

  task automatic tick;
    sf_tick_i <= 1'b1;
    @(posedge core_clk_i);
    sf_tick_i <= 1'b0;
    @(posedge core_clk_i);
  endtask

  task automatic slot(input logic [3:0] st, input logic [3:0] dy, input logic [2:0] b);
    {static_pool_i, dynamic_pool_i, slot_strobe_i} <= {st, dy, 1'b1};
    @(posedge core_clk_i);
    slot_strobe_i <= 1'b0;
    @(posedge core_clk_i);
    chk(slot_pool_o, st | dy);
    chk({logon_burst_o, control_burst_o, traffic_burst_o}, b);
  endtask

  task automatic t_regs;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0101);
    wr(8'h1c, 32'hffff);
    rd(8'h1c, 32'h0);
    rd(8'h50, 32'h0);
    tick();
    chk({vreq_valid_o, rreq_valid_o}, 6'h00);
    $display("t_regs done");
  endtask

  task automatic t_slots;
    logon_pending_i <= 1'b1;
    slot(4'h2, 4'h0, 3'b000);
    slot(4'h1, 4'h0, 3'b100);
    wr(8'h00, 32'h0001);
    logon_pending_i <= 1'b0;
    slot(4'h2, 4'h8, 3'b011);
    qos_hold_i <= 1'b1;
    slot(4'h0, 4'h8, 3'b000);
    qos_hold_i <= 1'b0;
    rd(8'h0c, 32'h1);
    $display("t_slots done");
  endtask

  task automatic t_volume;
    wr(8'h10, 32'h0100);
    for (int c = 0; c < 3; c++) begin
      wr(8'h30 + 8'(4 * c), 32'h00ff);
    end
    wr(8'h04, 32'h0102);
    wr(8'h00, 32'h8071);
    tick();
    chk({vreq_valid_o, vreq_abs_o}, 6'h3f);
    chk(vreq_value_o, 48'h0003_0001_0002);
    rd(8'h40, 32'h1_0002);
    {arrive_class_i, arrive_bytes_i, arrive_valid_i} <= {2'h0, 16'h0180, 1'b1};
    @(posedge core_clk_i);
    arrive_valid_i <= 1'b0;
    tick();
    chk({vreq_valid_o[0], vreq_abs_o[0], vreq_value_o[15:0]}, 18'h2_0002);
    {go, go_class} <= 3'b100;
    @(posedge core_clk_i);
    go <= 1'b0;
    @(posedge core_clk_i);
    rd(8'h40, 32'h1_0003);
    chk(bl0, 16'h0003);
    tick();
    chk(vreq_valid_o[0], 1'b0);
    tick();
    rd(8'h40, 32'h0);
    chk(bl0, 16'h0000);
    tick();
    chk({vreq_valid_o[0], vreq_abs_o[0], vreq_value_o[15:0]}, 18'h3_0002);
    @(posedge core_clk_i);
    chk(bl0, 16'h0002);
    $display("t_volume done");
  endtask

  task automatic t_rate;
    wr(8'h14, 32'h0010);
    wr(8'h24, 32'h0050);
    wr(8'h00, 32'h8771);
    tick();
    chk(rreq_valid_o, 3'b010);
    chk(rreq_value_o[31:16], 16'h0040);
    @(posedge core_clk_i);
    chk(r1, 16'h0040);
    tick();
    chk(rreq_valid_o, 3'b000);
    chk(r1, 16'h0000);
    rate_demand_i <= 48'h0000_0030_0020;
    tick();
    chk({rreq_valid_o, rreq_value_o[31:16]}, 19'h2_0030);
    @(posedge core_clk_i);
    chk(r1, 16'h0030);
    tick();
    chk(rreq_valid_o, 3'b000);
    tick();
    chk({rreq_valid_o, rreq_value_o[31:16]}, 19'h2_0030);
    $display("t_rate done");
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} = {43'h0, 4'h3};
    {sf_tick_i, slot_strobe_i, static_pool_i, dynamic_pool_i, logon_pending_i} = '0;
    {qos_hold_i, arrive_valid_i, arrive_class_i, arrive_bytes_i, go, go_class} = '0;
    backlog_i = 48'h0201_0100_0300;
    rate_demand_i = 48'h0000_0080_0020;
    nrst_i = 1'b0;
    repeat (3) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    t_regs();
    t_slots();
    t_volume();
    t_rate();
    test_done();
  end
endmodule // capacity_request_engine_tb
`default_nettype wire
